// File: usbsie_consts.vh
// Register map, field positions, reset values and timing for the USB SIE control block
`ifndef USBSIE_CONSTS_VH
`define USBSIE_CONSTS_VH

// ==============================
// Register byte addresses
`define USBSIE_A_SYS_CTRL 12'h000
`define USBSIE_A_PIN_STAT 12'h004
`define USBSIE_A_EP_REQ 12'h008
`define USBSIE_A_FIFO_CFG0 12'h00C
`define USBSIE_A_FIFO_CFG1 12'h010
`define USBSIE_A_LINK_STAT 12'h014
`define USBSIE_A_FIFO_EXT 12'h018
`define USBSIE_WIN_BIT 11

// ==============================
// System control fields
`define USBSIE_SC_ENG_DIS 6
`define USBSIE_SC_PD_OFF 5
`define USBSIE_SC_BUS_LVL 4
`define USBSIE_SC_RSVD 1
`define USBSIE_SC_ESD 0
`define USBSIE_SC_RST 8'h00

// ==============================
// Pin status fields
`define USBSIE_PS_ODB_OUT 7
`define USBSIE_PS_ODA_OUT 6
`define USBSIE_PS_ODB_IN 5
`define USBSIE_PS_ODA_IN 4
`define USBSIE_PS_SE1 3
`define USBSIE_PS_SE0 2
`define USBSIE_PS_PU 1
`define USBSIE_PS_RST 8'hC0

// ==============================
// Link status fields
`define USBSIE_LS_SUSPEND_INDICATOR 0
`define USBSIE_LS_RESUME 1
`define USBSIE_LS_BUSRST 2
`define USBSIE_LS_SUSPEND_INDICATOR_EV 3
`define USBSIE_LS_ACTIVE 4

// ==============================
// FIFO geometry
`define USBSIE_NUM_EP 8
`define USBSIE_MEM_DEPTH 512
`define USBSIE_EP0_SIZE 7'h08
`define USBSIE_CFG_RST 8'h00

// ==============================
// Timing
`define USBSIE_CLK_PERIOD_NS 50
`define USBSIE_SE0_GLITCH_NS 100
`define USBSIE_BUS_RESET_NS 2500
`define USBSIE_SE0_GLITCH_CYC (`USBSIE_SE0_GLITCH_NS / `USBSIE_CLK_PERIOD_NS)
`define USBSIE_BUS_RESET_CYC \
    ((`USBSIE_BUS_RESET_NS + `USBSIE_CLK_PERIOD_NS - 1) / `USBSIE_CLK_PERIOD_NS)

`endif

// File: usbsie_ctrl.v
// USB serial interface engine control, status and endpoint FIFO storage
// Notes on behaviour
// - Eight endpoints, 0 to 7, each with its own FIFO receiving decoded data.
// - Endpoints 1 to 7 have software-selected FIFO depth of 8, 16, 32 or 64.
// - Endpoint 0 FIFO is always eight bytes, not configurable.
// - Endpoint 0 carries control transfers; endpoints 1-7 interrupt or bulk.
// - Engine decodes host stream and stores payload in addressed endpoint FIFO.
// - FIFO storage sits at top of data memory, growing down with sizes.
// - Interrupt on endpoint FIFO access, suspend entry, resume or bus reset.
// - Engine disabled while disable bit 6 is 1; bit resets to 0.
// - Bus-power pin pull-low on when bit 5 is 0, off when 1.
// - Bit 4 reads the bus-power pin level.
// - Engine sets ESD flag bit 0; only software clears it.
// - Open-drain bits 7 and 6 drive NMOS pins and reset to 1.
// - Status bits 5 and 4 return the open-drain pin input levels.
// - Engine sets SE1 noise flag bit 3; software clears; resets to 0.
// - Engine sets SE0 noise flag bit 2; software clears; resets to 0.
// - Bit 1 set connects pull-ups on both data lines; clear removes them.
// - Engine stops whenever the bus-power pin has no power.
// - Host access sets endpoint request flag; software clears it after service.
// - Engine sets read-only suspend indicator; interrupt when it rises.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "usbsie_consts.vh"

module usbsie_ctrl (
    input wire ref_clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire bus_power_pin,
    input wire data_plus_pin,
    input wire data_minus_pin,
    input wire rx_valid,
    input wire [2:0] rx_ep,
    input wire [7:0] rx_byte,
    input wire rx_setup,
    input wire rx_end,
    input wire suspend_det,
    input wire resume_det,
    input wire esd_det,
    input wire opendrain_a_pin_i,
    input wire opendrain_b_pin_i,
    output reg opendrain_a_pin_o,
    output reg opendrain_a_pin_oe,
    output reg opendrain_b_pin_o,
    output reg opendrain_b_pin_oe,
    output reg bus_power_pulldown_en,
    output reg data_plus_pullup_en,
    output reg data_minus_pullup_en,
    output reg engine_active,
    output reg usb_irq
);

    // ==============================
    // Helpers
    function [6:0] size_of;
        input [1:0] code;
        begin
            size_of = 7'h08 << code;
        end
    endfunction

    function [7:0] lane_byte;
        input [11:0] adr;
        input [11:0] ofs;
        begin
            lane_byte = {8{reg_hit(adr, ofs)}};
        end
    endfunction

    function reg_hit;
        input [11:0] adr;
        input [11:0] ofs;
        begin
            reg_hit = (adr == ofs);
        end
    endfunction

    // ==============================
    // Registers
    reg [7:0] sys_ctrl_q;
    reg [7:0] sys_ctrl_d;
    reg [7:0] pin_stat_q;
    reg [7:0] pin_stat_d;
    reg [7:0] ep_req_q;
    reg [7:0] ep_req_d;
    reg [7:0] fifo_cfg0_q;
    reg [7:0] fifo_cfg1_q;
    reg suspend_indicator_q;
    reg suspend_indicator_ev_q;
    reg suspend_indicator_ev_d;
    reg resume_q;
    reg resume_d;
    reg busrst_q;
    reg busrst_d;
    reg [5:0] se0_cnt_q;
    reg se0_prev_q;
    reg [5:0] wr_ptr_q [0:7];
    reg [7:0] fifo_mem [0:`USBSIE_MEM_DEPTH-1];
    reg [31:0] rd_data;

    wire bus_req = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master sees ack
    // Every writable register sits in byte lane 0, so only sel[0] gates a write
    wire wr_en = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire [7:0] wd = wb_dat_i[7:0];
    // Upper half of the map is a byte window onto the FIFO memory
    wire win_hit = wb_adr_i[`USBSIE_WIN_BIT];
    wire [8:0] win_idx = wb_adr_i[10:2];

    // Mask of bits software clears by writing 0 at a given address
    wire [7:0] clr_sc = lane_byte(wb_adr_i, `USBSIE_A_SYS_CTRL) & ~wd & {8{wr_en}};
    wire [7:0] clr_ps = lane_byte(wb_adr_i, `USBSIE_A_PIN_STAT) & ~wd & {8{wr_en}};
    wire [7:0] clr_ep = lane_byte(wb_adr_i, `USBSIE_A_EP_REQ) & ~wd & {8{wr_en}};
    wire [7:0] clr_ls = lane_byte(wb_adr_i, `USBSIE_A_LINK_STAT) & ~wd & {8{wr_en}};
    wire wr_sc = wr_en & reg_hit(wb_adr_i, `USBSIE_A_SYS_CTRL);
    wire wr_ps = wr_en & reg_hit(wb_adr_i, `USBSIE_A_PIN_STAT);
    wire wr_cfg0 = wr_en & reg_hit(wb_adr_i, `USBSIE_A_FIFO_CFG0);
    wire wr_cfg1 = wr_en & reg_hit(wb_adr_i, `USBSIE_A_FIFO_CFG1);

    // ==============================
    // Engine enable
    // Without bus power the engine side is unpowered, whatever the control bit says
    wire eng_on = ~sys_ctrl_q[`USBSIE_SC_ENG_DIS] & bus_power_pin;
    // Suspend entry counts only on the rising edge of the indicator
    wire suspend_indicator_rise = suspend_det & eng_on & ~suspend_indicator_q;

    // ==============================
    // FIFO layout, packed down from the top of memory
    wire [15:0] cfg_all = {fifo_cfg1_q, fifo_cfg0_q[7:2], 2'b00};
    wire [6:0] ep_size [0:7];
    wire [8:0] ep_base [0:7];

    genvar g;
    generate
        for (g = 0; g < `USBSIE_NUM_EP; g = g + 1) begin : g_ep
            if (g == 0) begin : g_zero
                assign ep_size[g] = `USBSIE_EP0_SIZE;
                assign ep_base[g] = 9'h1F8;
            end else begin : g_rest
                assign ep_size[g] = size_of(cfg_all[2*g+1:2*g]);
                assign ep_base[g] = ep_base[g-1] - {2'b00, ep_size[g]};
            end
        end
    endgenerate

    // ==============================
    // Receive path
    // Setup tokens only belong on the control endpoint
    wire rx_ok = eng_on & ~(rx_setup & (rx_ep != 3'h0));
    wire rx_wr = rx_valid & rx_ok;
    wire rx_done = rx_end & rx_ok;
    wire [5:0] cur_ptr = wr_ptr_q[rx_ep];
    wire [8:0] rx_addr = ep_base[rx_ep] + {3'b000, cur_ptr};
    wire [6:0] ptr_inc = {1'b0, cur_ptr} + 7'h01;
    wire [5:0] ptr_nxt = (ptr_inc == ep_size[rx_ep]) ? 6'h00 : ptr_inc[5:0];

    // A packet longer than its FIFO wraps and overwrites its own first bytes
    integer i;
    always @(posedge ref_clk) begin
        if (rst) begin
            for (i = 0; i < `USBSIE_NUM_EP; i = i + 1) begin
                wr_ptr_q[i] <= 6'h00;
            end
        end else if (!eng_on) begin
            for (i = 0; i < `USBSIE_NUM_EP; i = i + 1) begin
                wr_ptr_q[i] <= 6'h00;
            end
        end else if (rx_valid && rx_ok) begin
            wr_ptr_q[rx_ep] <= rx_end ? 6'h00 : ptr_nxt;
        end else if (rx_done) begin
            wr_ptr_q[rx_ep] <= 6'h00;
        end
    end

    // Memory has no reset; software sees stale bytes until written
    always @(posedge ref_clk) begin
        if (wr_en && win_hit) begin
            fifo_mem[win_idx] <= wd;
        end
        // On a clash with a software write to the same byte the engine wins
        if (rx_wr) begin
            fifo_mem[rx_addr] <= rx_byte;
        end
    end

    // ==============================
    // Line condition monitor
    wire se0 = ~data_plus_pin & ~data_minus_pin;
    wire se1 = data_plus_pin & data_minus_pin;
    // Short SE0 is noise, long SE0 is a bus reset
    wire se0_end = se0_prev_q & ~se0;
    // Count widened once so the limit compares stay 32 bits on both sides
    wire [31:0] se0_len = {26'h0000000, se0_cnt_q};
    wire se0_glitch = se0_end & (se0_len <= `USBSIE_SE0_GLITCH_CYC);
    wire busrst_hit = se0 & (se0_len == (`USBSIE_BUS_RESET_CYC - 1));

    always @(posedge ref_clk) begin
        if (rst) begin
            se0_cnt_q <= 6'h00;
            se0_prev_q <= 1'b0;
        end else begin
            se0_prev_q <= se0 & eng_on;
            // Saturates so a held SE0 cannot wrap into a second bus reset
            if (!se0 || !eng_on) begin
                se0_cnt_q <= 6'h00;
            end else if (se0_cnt_q != 6'h3F) begin
                se0_cnt_q <= se0_cnt_q + 6'h01;
            end
        end
    end

    // ==============================
    // Next state of flags and controls
    always @* begin
        sys_ctrl_d = sys_ctrl_q;
        if (wr_sc) begin
            sys_ctrl_d[`USBSIE_SC_ENG_DIS] = wd[`USBSIE_SC_ENG_DIS];
            sys_ctrl_d[`USBSIE_SC_PD_OFF] = wd[`USBSIE_SC_PD_OFF];
            // Held at 0 whatever software writes
            sys_ctrl_d[`USBSIE_SC_RSVD] = 1'b0;
        end
        sys_ctrl_d[`USBSIE_SC_ESD] = (sys_ctrl_q[`USBSIE_SC_ESD]
            & ~clr_sc[`USBSIE_SC_ESD]) | (esd_det & eng_on);

        pin_stat_d = pin_stat_q;
        if (wr_ps) begin
            pin_stat_d[`USBSIE_PS_ODB_OUT] = wd[`USBSIE_PS_ODB_OUT];
            pin_stat_d[`USBSIE_PS_ODA_OUT] = wd[`USBSIE_PS_ODA_OUT];
            pin_stat_d[`USBSIE_PS_PU] = wd[`USBSIE_PS_PU];
        end
        pin_stat_d[`USBSIE_PS_SE1] = (pin_stat_q[`USBSIE_PS_SE1]
            & ~clr_ps[`USBSIE_PS_SE1]) | (se1 & eng_on);
        pin_stat_d[`USBSIE_PS_SE0] = (pin_stat_q[`USBSIE_PS_SE0]
            & ~clr_ps[`USBSIE_PS_SE0]) | se0_glitch;

        ep_req_d = ep_req_q & ~clr_ep;
        if (rx_done) begin
            ep_req_d[rx_ep] = 1'b1;
        end

        resume_d = (resume_q & ~clr_ls[`USBSIE_LS_RESUME])
            | (resume_det & eng_on);
        busrst_d = (busrst_q & ~clr_ls[`USBSIE_LS_BUSRST]) | busrst_hit;
        suspend_indicator_ev_d = (suspend_indicator_ev_q & ~clr_ls[`USBSIE_LS_SUSPEND_INDICATOR_EV])
            | suspend_indicator_rise;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            sys_ctrl_q <= `USBSIE_SC_RST;
            pin_stat_q <= `USBSIE_PS_RST;
            ep_req_q <= 8'h00;
            fifo_cfg0_q <= `USBSIE_CFG_RST;
            fifo_cfg1_q <= `USBSIE_CFG_RST;
            suspend_indicator_q <= 1'b0;
            suspend_indicator_ev_q <= 1'b0;
            resume_q <= 1'b0;
            busrst_q <= 1'b0;
        end else begin
            sys_ctrl_q <= sys_ctrl_d;
            pin_stat_q <= pin_stat_d;
            ep_req_q <= ep_req_d;
            suspend_indicator_q <= suspend_det & eng_on;
            suspend_indicator_ev_q <= suspend_indicator_ev_d;
            resume_q <= resume_d;
            busrst_q <= busrst_d;
            // Ep0 has no size field, so the two low bits always read 0
            if (wr_cfg0) begin
                fifo_cfg0_q <= {wd[7:2], 2'b00};
            end
            if (wr_cfg1) begin
                fifo_cfg1_q <= wd;
            end
        end
    end

    // ==============================
    // Pins and interrupt
    always @(posedge ref_clk) begin
        if (rst) begin
            opendrain_a_pin_o <= 1'b0;
            opendrain_b_pin_o <= 1'b0;
            opendrain_a_pin_oe <= 1'b0;
            opendrain_b_pin_oe <= 1'b0;
            bus_power_pulldown_en <= 1'b1;
            data_plus_pullup_en <= 1'b0;
            data_minus_pullup_en <= 1'b0;
            engine_active <= 1'b0;
            usb_irq <= 1'b0;
        end else begin
            // NMOS only pulls low; a 1 releases the pin
            opendrain_a_pin_o <= 1'b0;
            opendrain_b_pin_o <= 1'b0;
            opendrain_a_pin_oe <= ~pin_stat_d[`USBSIE_PS_ODA_OUT];
            opendrain_b_pin_oe <= ~pin_stat_d[`USBSIE_PS_ODB_OUT];
            bus_power_pulldown_en <= ~sys_ctrl_d[`USBSIE_SC_PD_OFF];
            data_plus_pullup_en <= pin_stat_d[`USBSIE_PS_PU];
            data_minus_pullup_en <= pin_stat_d[`USBSIE_PS_PU];
            engine_active <= eng_on;
            // Level output: stays up until software has cleared every endpoint request and link event flag
            usb_irq <= (|ep_req_d) | suspend_indicator_ev_d | resume_d | busrst_d;
        end
    end

    // ==============================
    // Register read mux
    // Reserved and unimplemented bits read 0
    always @* begin
        rd_data = 32'h0000_0000;
        if (win_hit) begin
            rd_data[7:0] = fifo_mem[win_idx];
        end else begin
            case (wb_adr_i)
                `USBSIE_A_SYS_CTRL: begin
                    rd_data[7:0] = sys_ctrl_q;
                    rd_data[`USBSIE_SC_BUS_LVL] = bus_power_pin;
                end
                `USBSIE_A_PIN_STAT: begin
                    rd_data[7:0] = pin_stat_q;
                    rd_data[`USBSIE_PS_ODB_IN] = opendrain_b_pin_i;
                    rd_data[`USBSIE_PS_ODA_IN] = opendrain_a_pin_i;
                end
                `USBSIE_A_EP_REQ: begin
                    rd_data[7:0] = ep_req_q;
                end
                `USBSIE_A_FIFO_CFG0: begin
                    rd_data[7:0] = fifo_cfg0_q;
                end
                `USBSIE_A_FIFO_CFG1: begin
                    rd_data[7:0] = fifo_cfg1_q;
                end
                `USBSIE_A_LINK_STAT: begin
                    rd_data[`USBSIE_LS_SUSPEND_INDICATOR] = suspend_indicator_q;
                    rd_data[`USBSIE_LS_RESUME] = resume_q;
                    rd_data[`USBSIE_LS_BUSRST] = busrst_q;
                    rd_data[`USBSIE_LS_SUSPEND_INDICATOR_EV] = suspend_indicator_ev_q;
                    rd_data[`USBSIE_LS_ACTIVE] = eng_on;
                end
                `USBSIE_A_FIFO_EXT: begin
                    rd_data[8:0] = ep_base[7];
                end
                default: begin
                    rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==============================
    // Wishbone slave: one wait state, every address answers
    always @(posedge ref_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            // A write leaves the last read data standing on the bus
            if (bus_req && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule // usbsie_ctrl

// File: usbsie_ctrl_assertions.sv
// Concurrent checks on the USB SIE control block ports
`timescale 1ns/1ps
`include "usbsie_consts.vh"
module usbsie_ctrl_chk (
    input wire ref_clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire bus_power_pin,
    input wire rx_end,
    input wire rx_setup,
    input wire opendrain_a_pin_i,
    input wire opendrain_b_pin_i,
    input wire opendrain_a_pin_o,
    input wire opendrain_b_pin_o,
    input wire opendrain_a_pin_oe,
    input wire bus_power_pulldown_en,
    input wire data_plus_pullup_en,
    input wire data_minus_pullup_en,
    input wire engine_active,
    input wire usb_irq
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);
// ==============================
// Decoded bus events
wire wr_hit = wb_ack_o & wb_we_i & wb_sel_i[0];
wire sc_wr = wr_hit & (wb_adr_i == `USBSIE_A_SYS_CTRL);
wire ps_wr = wr_hit & (wb_adr_i == `USBSIE_A_PIN_STAT);
wire sc_rd = wb_ack_o & !wb_we_i & (wb_adr_i == `USBSIE_A_SYS_CTRL);
wire ps_rd = wb_ack_o & !wb_we_i & (wb_adr_i == `USBSIE_A_PIN_STAT);
// ==============================
// Properties
ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after take");
pulldown_ctl_a: assert property (sc_wr |=> ##1 (bus_power_pulldown_en ==
    !$past(wb_dat_i[`USBSIE_SC_PD_OFF], 2))) else $error("pull-low not per control bit");
pullup_ctl_a: assert property (ps_wr |=> ##1 (data_plus_pullup_en ==
    $past(wb_dat_i[`USBSIE_PS_PU], 2))) else $error("pull-up not per control bit");
pullup_pair_a: assert property (data_plus_pullup_en == data_minus_pullup_en)
    else $error("data line pull-ups differ");
od_drive_a: assert property (ps_wr |=> ##1 (opendrain_a_pin_oe ==
    !$past(wb_dat_i[`USBSIE_PS_ODA_OUT], 2))) else $error("open drain enable wrong");
od_low_a: assert property (!opendrain_a_pin_o && !opendrain_b_pin_o)
    else $error("open drain drives high");
od_in_a: assert property (ps_rd |-> wb_dat_o[5:4] ==
    {$past(opendrain_b_pin_i), $past(opendrain_a_pin_i)}) else $error("pin input bits wrong");
bus_lvl_a: assert property (sc_rd |-> wb_dat_o[4] == $past(bus_power_pin))
    else $error("bus power level bit wrong");
no_power_a: assert property (!bus_power_pin |=> !engine_active)
    else $error("engine runs without bus power");
pkt_irq_a: assert property ((rx_end && !rx_setup ##1 engine_active) |-> usb_irq)
    else $error("no interrupt after packet");
cover property (sc_wr);
cover property (rx_end ##1 usb_irq);
cover property ($fell(engine_active));
endmodule // usbsie_ctrl_chk

// File: usbsie_host_model.sv
// Behavioural host side: bus power, line states and decoded receive stream
`timescale 1ns/1ps
module usbsie_host_model (
    input wire ref_clk,
    output reg bus_power_pin,
    output reg data_plus_pin,
    output reg data_minus_pin,
    output reg rx_valid,
    output reg [2:0] rx_ep,
    output reg [7:0] rx_byte,
    output reg rx_setup,
    output reg rx_end,
    output reg suspend_det,
    output reg resume_det,
    output reg esd_det
);
initial begin
    bus_power_pin = 1'b1;
    {data_plus_pin, data_minus_pin} = 2'h2;
    {rx_valid, rx_ep, rx_byte, rx_setup, rx_end} = 14'h0000;
    {suspend_det, resume_det, esd_det} = 3'h0;
end
// ==============================
// Stream and line tasks
task pkt(input [2:0] ep, input [3:0] n, input s, input [7:0] b0);
    integer k;
    begin
        for (k = 0; k < n; k = k + 1) begin
            @(posedge ref_clk);
            {rx_valid, rx_ep, rx_byte, rx_setup, rx_end} <= {1'b1, ep, b0 + k[7:0], s, k == n - 1};
        end
        @(posedge ref_clk);
        // Stale byte is inverted so nothing can latch it by luck
        {rx_valid, rx_end, rx_byte} <= {2'h0, ~rx_byte};
    end
endtask
task line(input dp, input dm, input integer n);
    begin
        @(posedge ref_clk);
        {data_plus_pin, data_minus_pin} <= {dp, dm};
        repeat (n) @(posedge ref_clk);
        {data_plus_pin, data_minus_pin} <= 2'h2;
    end
endtask
task esd;
    begin
        @(posedge ref_clk);
        esd_det <= 1'b1;
        @(posedge ref_clk);
        esd_det <= 1'b0;
    end
endtask
task resume;
    begin
        @(posedge ref_clk);
        resume_det <= 1'b1;
        @(posedge ref_clk);
        resume_det <= 1'b0;
    end
endtask
task power(input v);
    @(posedge ref_clk) bus_power_pin <= v;
endtask
task suspend_indicator(input v);
    @(posedge ref_clk) suspend_det <= v;
endtask
endmodule // usbsie_host_model

// File: tb_usbsie_ctrl.sv
// Self-checking bench for the USB SIE control block
`timescale 1ns/1ps
`include "usbsie_consts.vh"
module tb_usbsie_ctrl;
reg ref_clk = 1'b0;
reg rst = 1'b1;
reg wb_cyc_q = 1'b0, wb_stb_q = 1'b0, wb_we_q = 1'b0;
reg [11:0] wb_adr_q = 12'h000;
reg [31:0] wb_dat_q = 32'h00000000;
wire [31:0] wb_dat_o;
wire wb_ack_o, dp, dm, rxv, rxs, rxe, sus, res, esd, vbus, oda_o, oda_oe, odb_o, odb_oe;
wire pd_en, pup_en, pun_en, eng, irq;
wire [2:0] rxep;
wire [7:0] rxb;
integer fail_count = 0;
integer tests_run = 0;
always #25 ref_clk = ~ref_clk;
usbsie_ctrl dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_q), .wb_stb_i(wb_stb_q),
    .wb_we_i(wb_we_q), .wb_adr_i(wb_adr_q), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_q),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_power_pin(vbus), .data_plus_pin(dp),
    .data_minus_pin(dm), .rx_valid(rxv), .rx_ep(rxep), .rx_byte(rxb), .rx_setup(rxs),
    .rx_end(rxe), .suspend_det(sus), .resume_det(res), .esd_det(esd),
    .opendrain_a_pin_i(~oda_oe), .opendrain_b_pin_i(~odb_oe), .opendrain_a_pin_o(oda_o),
    .opendrain_a_pin_oe(oda_oe), .opendrain_b_pin_o(odb_o), .opendrain_b_pin_oe(odb_oe),
    .bus_power_pulldown_en(pd_en), .data_plus_pullup_en(pup_en),
    .data_minus_pullup_en(pun_en), .engine_active(eng), .usb_irq(irq));
usbsie_host_model host (.ref_clk(ref_clk), .bus_power_pin(vbus), .data_plus_pin(dp),
    .data_minus_pin(dm), .rx_valid(rxv), .rx_ep(rxep), .rx_byte(rxb), .rx_setup(rxs),
    .rx_end(rxe), .suspend_det(sus), .resume_det(res), .esd_det(esd));
// ==============================
// Bus and compare tasks
task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
        tests_run = tests_run + 1;
        if (s !== e) begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    end
endtask
task wbx(input [11:0] a, input w, input [7:0] d, output [31:0] q);
    integer n;
    begin
        @(posedge ref_clk);
        {wb_cyc_q, wb_stb_q, wb_we_q, wb_adr_q, wb_dat_q} <= {2'h3, w, a, 24'h000000, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n = n + 1;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk("bus ack", 32'h0, 32'h1);
        q = wb_dat_o;
        {wb_cyc_q, wb_stb_q} <= 2'h0;
    end
endtask
task wr(input [11:0] a, input [7:0] d);
    reg [31:0] q;
    begin
        wbx(a, 1'b1, d, q);
        // Outputs launched at the commit edge are settled one edge later
        @(posedge ref_clk);
    end
endtask
task rd(input [11:0] a, input [31:0] e);
    reg [31:0] q;
    begin
        wbx(a, 1'b0, 8'h00, q);
        chk($sformatf("register %h", a), q, e);
    end
endtask
task stop_test;
    begin
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    end
endtask
// ==============================
// Tests
initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`USBSIE_A_SYS_CTRL, 32'h10);
    rd(`USBSIE_A_PIN_STAT, 32'hF0);
    chk("pull-low", pd_en, 32'h1);
    rd(`USBSIE_A_EP_REQ, 32'h00);
    rd(`USBSIE_A_FIFO_EXT, 32'h1C0);
    rd(12'h01C, 32'h00);
    $display("reset test done");
    wr(`USBSIE_A_PIN_STAT, 8'h42);
    chk("pull-up", pup_en, 32'h1);
    chk("od b enable", odb_oe, 32'h1);
    rd(`USBSIE_A_PIN_STAT, 32'h52);
    wr(`USBSIE_A_PIN_STAT, 8'hC0);
    wr(`USBSIE_A_SYS_CTRL, 8'h20);
    chk("pull-low", pd_en, 32'h0);
    $display("pin test done");
    host.line(1'b1, 1'b1, 1);
    host.line(1'b0, 1'b0, 2);
    host.esd;
    rd(`USBSIE_A_PIN_STAT, 32'hFC);
    rd(`USBSIE_A_SYS_CTRL, 32'h31);
    wr(`USBSIE_A_PIN_STAT, 8'hC0);
    wr(`USBSIE_A_SYS_CTRL, 8'h00);
    rd(`USBSIE_A_PIN_STAT, 32'hC0 | 32'h30);
    rd(`USBSIE_A_SYS_CTRL, 32'h10);
    $display("flag test done");
    wr(`USBSIE_A_FIFO_CFG0, 8'h04);
    rd(`USBSIE_A_FIFO_EXT, 32'h1B8);
    host.pkt(3'h1, 4'h3, 1'b0, 8'hA5);
    host.pkt(3'h0, 4'h1, 1'b1, 8'h3C);
    host.pkt(3'h2, 4'h1, 1'b1, 8'h77);
    rd(`USBSIE_A_EP_REQ, 32'h03);
    chk("irq", irq, 32'h1);
    // Ep1 byte 1 sits at index 489, ep0 byte 0 at index 504
    rd(12'hFA4, 32'hA6);
    rd(12'hFE0, 32'h3C);
    wr(`USBSIE_A_EP_REQ, 8'h00);
    rd(`USBSIE_A_EP_REQ, 32'h00);
    chk("irq", irq, 32'h0);
    $display("fifo test done");
    wr(`USBSIE_A_SYS_CTRL, 8'h40);
    host.pkt(3'h3, 4'h1, 1'b0, 8'h11);
    rd(`USBSIE_A_EP_REQ, 32'h00);
    rd(`USBSIE_A_LINK_STAT, 32'h00);
    wr(`USBSIE_A_SYS_CTRL, 8'h00);
    rd(`USBSIE_A_LINK_STAT, 32'h10);
    host.power(1'b0);
    rd(`USBSIE_A_SYS_CTRL, 32'h00);
    chk("engine", eng, 32'h0);
    host.power(1'b1);
    $display("engine test done");
    host.line(1'b0, 1'b0, 50);
    rd(`USBSIE_A_LINK_STAT, 32'h14);
    chk("irq", irq, 32'h1);
    wr(`USBSIE_A_LINK_STAT, 8'h00);
    host.resume;
    rd(`USBSIE_A_LINK_STAT, 32'h12);
    wr(`USBSIE_A_LINK_STAT, 8'h00);
    rd(`USBSIE_A_PIN_STAT, 32'hF0);
    chk("irq", irq, 32'h0);
    $display("link event test done");
    host.suspend_indicator(1'b1);
    rd(`USBSIE_A_LINK_STAT, 32'h19);
    chk("irq", irq, 32'h1);
    $display("suspend test done");
    stop_test;
end
initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count = fail_count + 1;
    $display("watchdog expired");
    stop_test;
end
endmodule // tb_usbsie_ctrl
bind usbsie_ctrl usbsie_ctrl_chk u_chk (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_power_pin(bus_power_pin), .rx_end(rx_end), .rx_setup(rx_setup),
    .opendrain_a_pin_i(opendrain_a_pin_i), .opendrain_b_pin_i(opendrain_b_pin_i),
    .opendrain_a_pin_o(opendrain_a_pin_o), .opendrain_b_pin_o(opendrain_b_pin_o),
    .opendrain_a_pin_oe(opendrain_a_pin_oe), .bus_power_pulldown_en(bus_power_pulldown_en),
    .data_plus_pullup_en(data_plus_pullup_en), .data_minus_pullup_en(data_minus_pullup_en),
    .engine_active(engine_active), .usb_irq(usb_irq));
